// file: src/cca_top.sv
// two capture/compare units with timers, channel array and register port
`include "cca_consts.svh"

// What this block does
// - two units, sixteen channels each, thirty-two total
// - two reloadable 16-bit timers per unit
// - timer clock: prescaled system clock or gpt6
// - first timer of each unit counts external
// - per channel timer choice and capture/compare
// - one pin per channel, input or output
// - capture copies assigned timer on pin edge
// - every capture raises the channel request
// - capture edge: rising, falling or both
// - compare channels checked every timer step
// - mode 0: request only, pin untouched
// - mode 1: pin toggles on each match
// - mode 2: one request per timer period
// - mode 3: set on match, clear on overflow
// - double register: two channels toggle one pin
// - prescaler codes divide by 8 to 1024
// - overflow restarts timer from reload value
// - gpt6 overflow offered to all four timers
module cca_top (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [`CCA_ADDR_W-1:0] reg_addr,
	input wire cca_pkg::cca_word_type reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output cca_pkg::cca_word_type reg_rdata,
	input wire logic [31:0] cc_pin_in,
	output logic [31:0] cc_pin_out,
	output logic [31:0] cc_pin_oe,
	input wire logic [1:0] ext_count_in,
	input wire logic gp_timer_six_ovf,
	output logic [31:0] cc_req
);
	import cca_pkg::*;

	// synchronisers and edge history
	logic [31:0] pin_s1_q;
	logic [31:0] pin_s2_q;
	logic [31:0] pin_s3_q;
	logic [1:0] ext_s1_q;
	logic [1:0] ext_s2_q;
	logic [1:0] ext_s3_q;
	logic [`CCA_PRESC_W-1:0] presc_q;

	// timer state
	logic [3:0][15:0] tval_q;
	logic [3:0][15:0] reload_q;
	cca_tctl_type [3:0] tctl_q;
	logic [3:0][15:0] tval_d;
	logic [3:0][15:0] reload_d;
	cca_tctl_type [3:0] tctl_d;
	logic [3:0][15:0] tnext;
	logic [3:0] tick;
	logic [3:0] tovf;
	logic [3:0] ext_ev;
	logic [3:0] presc_hit;

	// channel state
	logic [31:0][15:0] cc_q;
	logic [31:0][15:0] cc_d;
	cca_chcfg_type [31:0] cfg_q;
	cca_chcfg_type [31:0] cfg_d;
	logic [31:0] shot_q;
	logic [31:0] shot_d;
	logic [31:0] req_d;
	logic [31:0] pin_d;
	logic [31:0] oe_d;
	logic [31:0] cap;
	logic [31:0] match;
	logic [31:0] qual;
	logic [31:0] ovf_c;
	logic [31:0] pair_hit;
	logic [31:0] slave;
	logic [31:0] req_clr;
	logic [31:0] rise;
	logic [31:0] fall;

	// register decode
	wire [5:0] off = reg_addr[5:0];
	wire unit_sel = reg_addr[`CCA_UNIT_BIT];
	wire [1:0] tidx = {unit_sel, off[0]};
	wire [1:0] tkind = off[2:1];
	wire tsel_reg = (off[5:3] == 3'h0) && (off[2:1] != 2'h3);
	wire req_reg = (off == `CCA_OFS_REQ);
	wire chsel_val = (off[5:4] == `CCA_OFS_CCVAL);
	wire chsel_cfg = (off[5:4] == `CCA_OFS_CCCFG);
	wire [4:0] chidx = {unit_sel, off[3:0]};
	wire [15:0] tmr_rd = (tkind == `CCA_OFS_TVAL) ? tval_q[tidx] :
		(tkind == `CCA_OFS_RELOAD) ? reload_q[tidx] : {10'h000, tctl_q[tidx]};
	wire [15:0] req_rd = unit_sel ? cc_req[31:16] : cc_req[15:0];
	wire [15:0] rd_val = tsel_reg ? tmr_rd : req_reg ? req_rd :
		chsel_val ? cc_q[chidx] : chsel_cfg ? {11'h000, cfg_q[chidx]} : 16'h0000;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pin_s1_q <= 32'h0000_0000;
			pin_s2_q <= 32'h0000_0000;
			pin_s3_q <= 32'h0000_0000;
			ext_s1_q <= 2'h0;
			ext_s2_q <= 2'h0;
			ext_s3_q <= 2'h0;
			presc_q <= 10'h000;
			reg_rdata <= 16'h0000;
		end else begin
			pin_s1_q <= cc_pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			ext_s1_q <= ext_count_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			presc_q <= presc_q + 10'h001;
			reg_rdata <= reg_rd ? rd_val : 16'h0000;
		end
	end

	genvar t;
	generate
		for (t = 0; t < 4; t++) begin : g_tmr
			wire [10:0] pspan = (`CCA_PRESC_MIN << tctl_q[t].presc) - 11'h001;
			wire wr_t = reg_wr && tsel_reg && (tidx == 2'(t));
			assign presc_hit[t] = ((presc_q & pspan[9:0]) == pspan[9:0]);
			// external count on first timer only
			if (t % 2 == 0) begin : g_ext
				assign ext_ev[t] = ext_s2_q[t / 2] & ~ext_s3_q[t / 2];
			end else begin : g_noext
				assign ext_ev[t] = 1'b0;
			end
			// clock source select; gpt6 overflow pulse
			assign tick[t] = tctl_q[t].run & (((tctl_q[t].src == CCA_SRC_PRESC) & presc_hit[t]) |
				((tctl_q[t].src == CCA_SRC_GPT6) & gp_timer_six_ovf) |
				((tctl_q[t].src == CCA_SRC_EXT) & ext_ev[t]));
			assign tovf[t] = tick[t] && (tval_q[t] == `CCA_TIMER_MAX);
			assign tnext[t] = tovf[t] ? reload_q[t] : tval_q[t] + 16'h0001;
			assign tval_d[t] = (wr_t && tkind == `CCA_OFS_TVAL) ? reg_wdata : tick[t] ? tnext[t] : tval_q[t];
			assign reload_d[t] = (wr_t && tkind == `CCA_OFS_RELOAD) ? reg_wdata : reload_q[t];
			assign tctl_d[t] = (wr_t && tkind == `CCA_OFS_TCTL) ? cca_tctl_type'(reg_wdata[5:0]) : tctl_q[t];
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tval_q <= {4{`CCA_TVAL_RST}};
			reload_q <= {4{`CCA_RELOAD_RST}};
			tctl_q <= {4{`CCA_TCTL_RST}};
		end else begin
			tval_q <= tval_d;
			reload_q <= reload_d;
			tctl_q <= tctl_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_ch
			// timer of own unit chosen per channel
			wire [1:0] ti = {1'(g / 16), cfg_q[g].tsel};
			wire is_cmp = (cfg_q[g].mode >= CCA_CMP0);
			wire once = (cfg_q[g].mode == CCA_CMP2) || (cfg_q[g].mode == CCA_CMP3);
			wire is_m1 = (cfg_q[g].mode == CCA_CMP1);
			wire is_m3 = (cfg_q[g].mode == CCA_CMP3);
			wire wr_cc = reg_wr && chsel_val && (chidx == 5'(g));
			wire wr_cfg = reg_wr && chsel_cfg && (chidx == 5'(g));
			assign rise[g] = pin_s2_q[g] & ~pin_s3_q[g];
			assign fall[g] = ~pin_s2_q[g] & pin_s3_q[g];
			assign cap[g] = ((cfg_q[g].mode == CCA_CAP_RISE) & rise[g]) |
				((cfg_q[g].mode == CCA_CAP_FALL) & fall[g]) |
				((cfg_q[g].mode == CCA_CAP_BOTH) & (rise[g] | fall[g]));
			// compare on every step of assigned timer
			assign match[g] = is_cmp & tick[ti] & (tnext[ti] == cc_q[g]);
			assign qual[g] = match[g] & ~(once & shot_q[g]);
			assign ovf_c[g] = tovf[ti];
			assign shot_d[g] = once & (qual[g] | (shot_q[g] & ~ovf_c[g]));
			// lower channel of a pair owns the pin
			if (g % 16 < 8) begin : g_lo
				assign pair_hit[g] = cfg_q[g].pair & is_m1 & match[g + 8];
				assign slave[g] = 1'b0;
			end else begin : g_hi
				assign pair_hit[g] = 1'b0;
				assign slave[g] = cfg_q[g - 8].pair & (cfg_q[g - 8].mode == CCA_CMP1);
			end
			// pin driven only by driving compare modes
			assign oe_d[g] = (is_m1 | is_m3) & ~slave[g];
			// pin actions; mode 0 and 2 leave it
			assign pin_d[g] = (is_m1 & (qual[g] | pair_hit[g])) ? ~cc_pin_out[g] :
				(is_m3 & qual[g]) ? 1'b1 : (is_m3 & ovf_c[g]) ? 1'b0 : cc_pin_out[g];
			// sticky request, set wins over clear
			assign req_clr[g] = reg_wr & req_reg & (unit_sel == 1'(g / 16)) & reg_wdata[g % 16];
			assign req_d[g] = cap[g] | qual[g] | (cc_req[g] & ~req_clr[g]);
			// capture wins over a software write
			assign cc_d[g] = cap[g] ? tval_q[ti] : wr_cc ? reg_wdata : cc_q[g];
			assign cfg_d[g] = wr_cfg ? cca_chcfg_type'(reg_wdata[4:0]) : cfg_q[g];
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cc_q <= {32{16'h0000}};
			cfg_q <= {32{`CCA_CCCFG_RST}};
			shot_q <= 32'h0000_0000;
			cc_req <= 32'h0000_0000;
			cc_pin_out <= 32'h0000_0000;
			cc_pin_oe <= 32'h0000_0000;
		end else begin
			cc_q <= cc_d;
			cfg_q <= cfg_d;
			shot_q <= shot_d;
			cc_req <= req_d;
			cc_pin_out <= pin_d;
			cc_pin_oe <= oe_d;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	property p_capture;
		cap[1] |=> cc_q[1] == $past(tval_q[{1'b0, cfg_q[1].tsel}]);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	property p_cap_req;
		cap[1] |=> cc_req[1];
	endproperty
	a_cap_req: assert property (p_cap_req) else $error("capture did not raise request");

	property p_edge;
		(cfg_q[1].mode == CCA_CAP_RISE) && fall[1] |-> !cap[1];
	endproperty
	a_edge: assert property (p_edge) else $error("falling edge captured in rising mode");

	property p_mode0;
		(cfg_q[4].mode == CCA_CMP0) && match[4] |=> (cc_pin_out[4] == $past(cc_pin_out[4])) && cc_req[4];
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode 0 match touched pin or lost request");

	property p_toggle;
		(cfg_q[0].mode == CCA_CMP1) && match[0] && !pair_hit[0] |=> cc_pin_out[0] != $past(cc_pin_out[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("mode 1 pin did not toggle");

	property p_once;
		(cfg_q[3].mode == CCA_CMP2) && shot_q[3] |-> !qual[3];
	endproperty
	a_once: assert property (p_once) else $error("second compare event in one period");

	property p_mode3;
		(cfg_q[2].mode == CCA_CMP3) && ovf_c[2] && !qual[2] |=> !cc_pin_out[2];
	endproperty
	a_mode3: assert property (p_mode3) else $error("mode 3 pin not cleared on overflow");

	property p_double;
		cfg_q[0].pair && (cfg_q[0].mode == CCA_CMP1) && match[8] && !match[0]
			|=> cc_pin_out[0] != $past(cc_pin_out[0]);
	endproperty
	a_double: assert property (p_double) else $error("partner match did not toggle shared pin");

	property p_reload;
		tovf[0] && !reg_wr |=> tval_q[0] == $past(reload_q[0]);
	endproperty
	a_reload: assert property (p_reload) else $error("timer not reloaded on overflow");

	property p_presc;
		tctl_q[3].run && (tctl_q[3].src == CCA_SRC_PRESC) && (tctl_q[3].presc == 3'h1)
			|-> tick[3] == (presc_q[3:0] == 4'hf);
	endproperty
	a_presc: assert property (p_presc) else $error("divide by 16 tick wrong");

	property p_req_hold;
		cc_req[4] && !req_clr[4] |=> cc_req[4];
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped without clear");

	property p_oe_quiet;
		cfg_q[4].mode == CCA_CMP0 |=> !cc_pin_oe[4];
	endproperty
	a_oe_quiet: assert property (p_oe_quiet) else $error("mode 0 channel drives its pin");

	property p_slave_oe;
		cfg_q[0].pair && (cfg_q[0].mode == CCA_CMP1) |=> !cc_pin_oe[8];
	endproperty
	a_slave_oe: assert property (p_slave_oe) else $error("paired upper channel drives its pin");

	property p_req_read;
		reg_rd && req_reg && !unit_sel |=> reg_rdata == $past(cc_req[15:0]);
	endproperty
	a_req_read: assert property (p_req_read) else $error("request read wrong");

	property p_ext;
		tctl_q[0].run && (tctl_q[0].src == CCA_SRC_EXT) && ext_ev[0] && !reg_wr && (tval_q[0] != 16'hffff)
			|=> tval_q[0] == $past(tval_q[0]) + 16'h0001;
	endproperty
	a_ext: assert property (p_ext) else $error("external count did not step timer");

	property p_gp6;
		tctl_q[0].run && (tctl_q[0].src == CCA_SRC_GPT6) && gp_timer_six_ovf |-> tick[0];
	endproperty
	a_gp6: assert property (p_gp6) else $error("gpt6 overflow did not step timer");

	property p_src_none;
		tctl_q[1].src == CCA_SRC_NONE |-> !tick[1];
	endproperty
	a_src_none: assert property (p_src_none) else $error("timer stepped with no source");

	property p_stopped;
		!tctl_q[3].run |-> !tick[3];
	endproperty
	a_stopped: assert property (p_stopped) else $error("stopped timer stepped");

	property p_shot_clr;
		(cfg_q[2].mode == CCA_CMP3) && shot_q[2] && ovf_c[2] && !qual[2] |=> !shot_q[2];
	endproperty
	a_shot_clr: assert property (p_shot_clr) else $error("one-shot not cleared on overflow");

	property p_m2_pin;
		cfg_q[3].mode == CCA_CMP2 |=> cc_pin_out[3] == $past(cc_pin_out[3]);
	endproperty
	a_m2_pin: assert property (p_m2_pin) else $error("mode 2 changed pin");

	property p_cap_both;
		(cfg_q[1].mode == CCA_CAP_BOTH) && (rise[1] || fall[1]) |-> cap[1];
	endproperty
	a_cap_both: assert property (p_cap_both) else $error("edge missed in both-edge mode");

	property p_cmp_req;
		qual[0] |=> cc_req[0];
	endproperty
	a_cmp_req: assert property (p_cmp_req) else $error("compare event did not raise request");

	property p_req_clr;
		reg_wr && req_reg && !unit_sel && reg_wdata[4] && !cap[4] && !qual[4] |=> !cc_req[4];
	endproperty
	a_req_clr: assert property (p_req_clr) else $error("request not cleared by software");

	property p_m3_set;
		(cfg_q[2].mode == CCA_CMP3) && qual[2] |=> cc_pin_out[2];
	endproperty
	a_m3_set: assert property (p_m3_set) else $error("mode 3 pin not set on match");
endmodule : cca_top

// file: src/cca_consts.svh
// register offsets, field widths and reset values of the capture/compare array
`ifndef CCA_CONSTS_SVH
`define CCA_CONSTS_SVH
`define CCA_ADDR_W 7
`define CCA_UNIT_BIT 6
`define CCA_OFS_TVAL 2'h0
`define CCA_OFS_RELOAD 2'h1
`define CCA_OFS_TCTL 2'h2
`define CCA_OFS_REQ 6'h06
`define CCA_OFS_CCVAL 2'h1
`define CCA_OFS_CCCFG 2'h2
`define CCA_PRESC_W 10
`define CCA_PRESC_MIN 11'h008
`define CCA_TVAL_RST 16'h0000
`define CCA_RELOAD_RST 16'h0000
`define CCA_TCTL_RST 6'h00
`define CCA_CCCFG_RST 5'h00
`define CCA_TIMER_MAX 16'hffff
`endif

// file: src/cca_pkg.sv
// types shared by the capture/compare array
package cca_pkg;
	typedef logic [15:0] cca_word_type;
	typedef enum logic [2:0] {
		CCA_OFF, CCA_CAP_RISE, CCA_CAP_FALL, CCA_CAP_BOTH,
		CCA_CMP0, CCA_CMP1, CCA_CMP2, CCA_CMP3
	} cca_mode_type;
	typedef enum logic [1:0] {
		CCA_SRC_PRESC, CCA_SRC_GPT6, CCA_SRC_EXT, CCA_SRC_NONE
	} cca_src_type;
	typedef struct packed {
		logic [2:0] presc;
		cca_src_type src;
		logic run;
	} cca_tctl_type;
	typedef struct packed {
		logic pair;
		logic tsel;
		cca_mode_type mode;
	} cca_chcfg_type;
endpackage : cca_pkg

// file: test/cca_pins.sv
// pin model: external levels on the channel pins
module cca_pins (
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe,
	input wire logic [31:0] pin_drv,
	output logic [31:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drv);
endmodule : cca_pins

// file: test/dual_capture_compare_array_bench.sv
// bench for the capture/compare array
module dual_capture_compare_array_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cca_pkg::*;
	logic clk_sys = 0;
	logic sys_rst = 1;
	logic [6:0] addr = 0;
	cca_word_type wdata = 0;
	logic wr = 0;
	logic rd = 0;
	cca_word_type rdata;
	wire logic [31:0] pin_in;
	logic [31:0] pin_out;
	logic [31:0] pin_oe;
	logic [31:0] drv = 0;
	logic [1:0] ext = 0;
	logic gp6 = 0;
	logic [31:0] req;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	cca_word_type v;
	cca_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .cc_pin_in(pin_in), .cc_pin_out(pin_out),
		.cc_pin_oe(pin_oe), .ext_count_in(ext), .gp_timer_six_ovf(gp6), .cc_req(req));
	cca_pins pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_drv(drv), .pin_in(pin_in));
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic chk16(input string what, input cca_word_type exp, input cca_word_type got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk16
	task automatic chk1(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %b got %b", what, exp, got);
		end
	endtask : chk1
	task automatic wreg(input logic [6:0] a, input cca_word_type d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk_sys);
		wr <= 0;
	endtask : wreg
	task automatic rreg(input logic [6:0] a, output cca_word_type d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1;
		@(posedge clk_sys);
		rd <= 0;
		#1 d = rdata;
	endtask : rreg
	// one timer step from the gp timer six overflow
	task automatic tick;
		@(posedge clk_sys);
		gp6 <= 1;
		@(posedge clk_sys);
		gp6 <= 0;
		@(posedge clk_sys);
		#1;
	endtask : tick
	initial begin
		repeat (2) @(posedge clk_sys);
		sys_rst <= 0;
		rreg(7'h02, v);
		chk16("reload reset", 16'h0000, v);
		rreg(7'h20, v);
		chk16("cfg reset", 16'h0000, v);
		wreg(7'h02, 16'h1234);
		wreg(7'h10, 16'h0003);
		wreg(7'h12, 16'h0005);
		wreg(7'h20, 16'h0005);
		wreg(7'h21, 16'h0001);
		wreg(7'h22, 16'h0007);
		wreg(7'h04, 16'h0003);
		wreg(7'h00, 16'h0002);
		tick();
		chk1("ch0 pin", 1'b1, pin_out[0]);
		chk1("ch0 oe", 1'b1, pin_oe[0]);
		chk1("ch0 req", 1'b1, req[0]);
		chk1("ch2 pin", 1'b0, pin_out[2]);
		tick();
		tick();
		chk1("ch2 set", 1'b1, pin_out[2]);
		chk1("ch2 req", 1'b1, req[2]);
		chk1("ch0 held", 1'b1, pin_out[0]);
		$display("test compare done");
		tick();
		@(posedge clk_sys);
		drv <= 32'h0000_0002;
		repeat (5) @(posedge clk_sys);
		rreg(7'h11, v);
		chk16("capture", 16'h0006, v);
		chk1("cap req", 1'b1, req[1]);
		$display("test capture done");
		wreg(7'h00, 16'hffff);
		tick();
		chk1("ch2 clear", 1'b0, pin_out[2]);
		rreg(7'h00, v);
		chk16("reload", 16'h1234, v);
		chk1("req sticky", 1'b1, req[0]);
		@(posedge clk_sys);
		drv <= 32'h0000_0000;
		repeat (5) @(posedge clk_sys);
		rreg(7'h11, v);
		chk16("no fall capture", 16'h0006, v);
		wreg(7'h06, 16'h0007);
		rreg(7'h06, v);
		chk16("req clear", 16'h0000, v);
		rreg(7'h08, v);
		chk16("unmapped", 16'h0000, v);
		wreg(7'h13, 16'h1236);
		wreg(7'h23, 16'h0006);
		wreg(7'h14, 16'h1236);
		wreg(7'h24, 16'h0004);
		tick();
		tick();
		chk1("ch3 req", 1'b1, req[3]);
		chk1("ch4 req", 1'b1, req[4]);
		chk1("ch4 oe", 1'b0, pin_oe[4]);
		wreg(7'h06, 16'h0018);
		wreg(7'h00, 16'h1235);
		tick();
		chk1("ch3 once", 1'b0, req[3]);
		chk1("ch4 again", 1'b1, req[4]);
		wreg(7'h18, 16'h1237);
		wreg(7'h28, 16'h0005);
		wreg(7'h20, 16'h0015);
		tick();
		chk1("pair pin", 1'b0, pin_out[0]);
		chk1("pair oe", 1'b0, pin_oe[8]);
		chk1("pair req", 1'b1, req[8]);
		wreg(7'h21, 16'h0003);
		@(posedge clk_sys);
		drv <= 32'h0000_0002;
		repeat (5) @(posedge clk_sys);
		rreg(7'h11, v);
		chk16("both capture", 16'h1237, v);
		wreg(7'h04, 16'h0005);
		@(posedge clk_sys);
		ext <= 2'h1;
		@(posedge clk_sys);
		ext <= 2'h0;
		repeat (5) @(posedge clk_sys);
		rreg(7'h00, v);
		chk16("ext count", 16'h1238, v);
		$display("test modes done");
		wreg(7'h45, 16'h0009);
		repeat (160) @(posedge clk_sys);
		rreg(7'h41, v);
		chk1("div16", 1'b1, v >= 16'h0009 && v <= 16'h000b);
		$display("test timer done");
		wrap_up();
	end
endmodule : dual_capture_compare_array_bench
